/* File: src/smd_map.vh */
// Contract
// - two status bytes per slot follow the two coupling bytes, slot 1 first.
// - dual-width module: both slots share byte-1 layout, only first slot active.
// - byte-1 bit 7 set while the slot module is active.
// - byte-1 bit 6 set while any channel is simulated.
// - byte-1 bit 5 set on module error; bit 4 reads zero.
// - error code 1 on slot timeout (no module), 0 when no fault.
// - error code 2 to 6 on internal bus communication failure.
// - error code 9 when inserted type differs from configured type.
// - error code 10 on internal module fault such as lead breakage.
// - families without channel diagnostics hold byte 2 at zero.
// - digital: data in even bits, invalid flag in odd bits, channels 1 to 4.
// - byte 4 only for dual-width modules, channels 5 to 8 same pattern.
// - channel bits beyond the module channel count read as reserved zero; counter state and invalid bits are not masked by the count.
// - relay pair: channel 1 in bit 0, channel 2 in bit 1, rest zero.
// - counter: state bit 0, invalid bit 1, direction bit 3, rest zero.
// - analog current: undershoot bits 0 and 4, invalid bits 1 and 5.
`ifndef SMD_MAP_VH
`define SMD_MAP_VH
`define SMD_NSLOT 8
`define SMD_SLOT_W 3
// byte addresses on the avalon bus (word index times four)
`define SMD_ADDR_W 6
`define SMD_A_GLOBAL 6'h00
`define SMD_A_SLOT0 6'h04
`define SMD_A_SLOTL 6'h20
`define SMD_A_IRQ_STAT 6'h30
`define SMD_A_IRQ_MASK 6'h34
`define SMD_A_SLOT_IDX_LSB 2
// byte-1 fields
`define SMD_B1_ACT 7
`define SMD_B1_SIM 6
`define SMD_B1_ERR 5
// error codes
`define SMD_EC_NONE 4'h0
`define SMD_EC_TMO 4'h1
`define SMD_EC_BUS_MIN 4'h2
`define SMD_EC_BUS_MAX 4'h6
`define SMD_EC_TYPE 4'h9
`define SMD_EC_INT 4'ha
// module families
`define SMD_F_NONE 3'h0
`define SMD_F_DIG 3'h1
`define SMD_F_RELAY 3'h2
`define SMD_F_CNT 3'h3
`define SMD_F_ANA 3'h4
`define SMD_DEADBEEF 32'hbad0_0000
`endif

/* File: src/smd_status.v */
// The Avalon-MM slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "smd_map.vh"
// per-slot module diagnostic status bank; each slot word = {byte4,byte2,byte1}
// in bits [23:16],[15:8],[7:0]; a dual-width second slot shows byte3 = byte1
// without active and byte4 is carried in the first slot word
module smd_status (
   input wire I_CLK,
   input wire I_RSTN,
   // avalon-mm slave
   input wire [5:0] I_AVS_ADDRESS,
   input wire I_AVS_READ,
   input wire I_AVS_WRITE,
   input wire [31:0] I_AVS_WRITEDATA,
   input wire [3:0] I_AVS_BYTEENABLE,
   output reg [31:0] O_AVS_READDATA,
   output wire O_AVS_WAITREQUEST,
   output wire O_IRQ,
   // global coupling bytes
   input wire [15:0] I_GLOBAL_STATUS,
   // slot inputs, one field per slot
   input wire [7:0] I_PRESENT,
   input wire [7:0] I_ENABLED,
   input wire [7:0] I_DUAL_SECOND,
   input wire [7:0] I_TYPE_MISMATCH,
   input wire [7:0] I_INT_FAULT,
   input wire [23:0] I_BUS_ERR_CODE,
   input wire [23:0] I_FAMILY,
   input wire [31:0] I_CHAN_CNT,
   input wire [63:0] I_CHAN_DATA,
   input wire [63:0] I_CHAN_INVALID,
   input wire [63:0] I_CHAN_SIM,
   input wire [7:0] I_CNT_DIR
);
   reg [23:0] slot_reg [0:`SMD_NSLOT-1];
   reg [7:0] irq_stat_reg;
   reg [7:0] irq_mask_reg;
   reg ack_reg;
   wire [`SMD_SLOT_W-1:0] a_idx;
   integer k;
   integer j; // loop index of the bus process, so each index has one driver

   // error code, priority: absent, bus, type, internal fault
   function [3:0] err_code;
      input present;
      input [2:0] bus;
      input mism;
      input intf;
      begin
         err_code = `SMD_EC_NONE;
         if (!present)
            err_code = `SMD_EC_TMO;
         else if (bus != 3'h0)
            err_code = (bus > 3'h5) ? `SMD_EC_BUS_MAX : {1'b0, bus} + 4'h1;
         else if (mism)
            err_code = `SMD_EC_TYPE;
         else if (intf)
            err_code = `SMD_EC_INT;
      end
   endfunction

   // channel byte for a group of four channels; cnt counts channels in group
   function [7:0] chan_byte;
      input [2:0] fam;
      input [3:0] dat;
      input [3:0] inv;
      input [2:0] cnt;
      input dir;
      reg [3:0] m;
      begin
         m = (cnt >= 3'h4) ? 4'hf : ((4'h1 << cnt) - 4'h1);
         chan_byte = 8'h00;
         case (fam)
            `SMD_F_DIG: chan_byte = {inv[3] & m[3], dat[3] & m[3], inv[2] & m[2], dat[2] & m[2],
                                     inv[1] & m[1], dat[1] & m[1], inv[0] & m[0],
                                     dat[0] & m[0]};
            `SMD_F_RELAY: chan_byte = {6'h00, dat[1] & m[1], dat[0] & m[0]};
            `SMD_F_CNT: chan_byte = {4'h0, dir, 1'b0, inv[0], dat[0]};
            `SMD_F_ANA: chan_byte = {2'h0, inv[1] & m[1], dat[1] & m[1], 2'h0,
                                     inv[0] & m[0], dat[0] & m[0]};
            default: chan_byte = 8'h00;
         endcase
      end
   endfunction

   // rebuild every slot word each cycle so reads are always current
   always @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         for (k = 0; k < `SMD_NSLOT; k = k + 1)
            slot_reg[k] <= 24'h000000;
      end else begin
         for (k = 0; k < `SMD_NSLOT; k = k + 1) begin : upd
            reg [3:0] ec;
            reg [7:0] c8;
            ec = err_code(I_PRESENT[k], I_BUS_ERR_CODE[k*3 +: 3], I_TYPE_MISMATCH[k],
                          I_INT_FAULT[k]);
            c8 = I_CHAN_CNT[k*4 +: 4] > 4'h4 ? 8'h04 : {4'h0, I_CHAN_CNT[k*4 +: 4]};
            slot_reg[k][7:0] <= {I_PRESENT[k] & I_ENABLED[k] & ~I_DUAL_SECOND[k],
                                 |(I_CHAN_SIM[k*8 +: 8]),
                                 ec != `SMD_EC_NONE, 1'b0, ec};
            slot_reg[k][15:8] <= (I_DUAL_SECOND[k] || !I_PRESENT[k]) ? 8'h00 :
               chan_byte(I_FAMILY[k*3 +: 3], I_CHAN_DATA[k*8 +: 4], I_CHAN_INVALID[k*8 +: 4],
                         c8[2:0], I_CNT_DIR[k]);
            // upper four channels only exist on a dual-width module
            slot_reg[k][23:16] <= (I_CHAN_CNT[k*4 +: 4] > 4'h4 && I_PRESENT[k]) ?
               chan_byte(I_FAMILY[k*3 +: 3], I_CHAN_DATA[k*8+4 +: 4],
                         I_CHAN_INVALID[k*8+4 +: 4], I_CHAN_CNT[k*4 +: 3] - 3'h4,
                         1'b0) : 8'h00;
         end
      end
   end

   assign a_idx = I_AVS_ADDRESS[`SMD_A_SLOT_IDX_LSB +: `SMD_SLOT_W];

   // one wait state per access so read data come from a flop
   assign O_AVS_WAITREQUEST = (I_AVS_READ | I_AVS_WRITE) & ~ack_reg;
   assign O_IRQ = |(irq_stat_reg & irq_mask_reg);

   // bus slave, interrupt status (error per slot, set beats read clear)
   always @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         ack_reg <= 1'b0;
         O_AVS_READDATA <= 32'h00000000;
         irq_stat_reg <= 8'h00;
         irq_mask_reg <= 8'h00;
      end else begin
         ack_reg <= (I_AVS_READ | I_AVS_WRITE) & ~ack_reg;
         for (j = 0; j < `SMD_NSLOT; j = j + 1)
            if (slot_reg[j][`SMD_B1_ERR])
               irq_stat_reg[j] <= 1'b1;
         if (I_AVS_READ && !ack_reg) begin
            if (I_AVS_ADDRESS == `SMD_A_GLOBAL)
               O_AVS_READDATA <= {16'h0000, I_GLOBAL_STATUS};
            else if (I_AVS_ADDRESS >= `SMD_A_SLOT0 && I_AVS_ADDRESS <= `SMD_A_SLOTL)
               O_AVS_READDATA <= {8'h00, slot_reg[a_idx - 3'h1]};
            else if (I_AVS_ADDRESS == `SMD_A_IRQ_STAT) begin
               O_AVS_READDATA <= {24'h000000, irq_stat_reg};
               for (j = 0; j < `SMD_NSLOT; j = j + 1)
                  if (!slot_reg[j][`SMD_B1_ERR])
                     irq_stat_reg[j] <= 1'b0;
            end else if (I_AVS_ADDRESS == `SMD_A_IRQ_MASK)
               O_AVS_READDATA <= {24'h000000, irq_mask_reg};
            else
               O_AVS_READDATA <= `SMD_DEADBEEF;
         end
         // a write lands only at the edge where waitrequest is low
         if (I_AVS_WRITE && ack_reg && I_AVS_ADDRESS == `SMD_A_IRQ_MASK && I_AVS_BYTEENABLE[0])
            irq_mask_reg <= I_AVS_WRITEDATA[7:0];
      end
   end
endmodule // smd_status
`default_nettype wire

/* File: verification/slot_module_diagnostic_status_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module slot_module_diagnostic_status_bench;
   logic I_CLK = 0, I_RSTN = 0, I_AVS_READ = 0, I_AVS_WRITE = 0, O_AVS_WAITREQUEST, O_IRQ;
   logic [5:0] I_AVS_ADDRESS = 6'h00;
   logic [3:0] I_AVS_BYTEENABLE = 4'h0;
   logic [31:0] I_AVS_WRITEDATA = 32'h0, O_AVS_READDATA, I_CHAN_CNT;
   logic [7:0] I_PRESENT, I_DUAL_SECOND;
   logic [23:0] I_FAMILY;
   logic [63:0] I_CHAN_DATA, I_CHAN_INVALID, I_CHAN_SIM;
   logic [1:0] scene = 2'h0;
   logic [23:0] exp1 [8] = '{24'h2580, 24'h280, 24'h980, 24'h2180, 24'ha9, 24'haa, 24'ha4, 24'hc0};
   int n_fail = 0, comparisons = 0, cyc = 0;
   smd_status dut (.I_CLK, .I_RSTN, .I_AVS_ADDRESS, .I_AVS_READ, .I_AVS_WRITE, .I_AVS_WRITEDATA,
      .I_AVS_BYTEENABLE, .O_AVS_READDATA, .O_AVS_WAITREQUEST, .O_IRQ, .I_GLOBAL_STATUS(16'h1234),
      .I_PRESENT, .I_ENABLED(I_PRESENT), .I_DUAL_SECOND, .I_TYPE_MISMATCH(8'h10),
      .I_INT_FAULT(8'h20), .I_BUS_ERR_CODE(24'h0c0000), .I_FAMILY, .I_CHAN_CNT, .I_CHAN_DATA,
      .I_CHAN_INVALID, .I_CHAN_SIM, .I_CNT_DIR(8'h04));
   smd_io_model io (.i_scene(scene), .o_on(I_PRESENT), .o_dual(I_DUAL_SECOND), .o_fam(I_FAMILY),
      .o_cnt(I_CHAN_CNT), .o_dat(I_CHAN_DATA), .o_inv(I_CHAN_INVALID), .o_sim(I_CHAN_SIM));
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         n_fail++;
         $display("wrong value at %0t: got %h want %h", $time, s, e);
      end
   endtask
   // one avalon transfer; waitrequest and data are read at the edge, before its updates land
   task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] e);
      @(posedge I_CLK);
      I_AVS_READ <= !w;
      I_AVS_WRITE <= w;
      I_AVS_ADDRESS <= a;
      I_AVS_WRITEDATA <= e;
      I_AVS_BYTEENABLE <= w ? 4'h1 : 4'hf;
      do
         @(posedge I_CLK);
      while (O_AVS_WAITREQUEST !== 1'b0);
      if (!w)
         chk(O_AVS_READDATA, e);
      I_AVS_READ <= 1'b0;
      I_AVS_WRITE <= 1'b0;
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // clock and hang guard, the run needs under a hundred cycles
   always #5 I_CLK = ~I_CLK;
   always @(posedge I_CLK) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         end_of_test();
      end
   end
   // empty rack, then mixed families with irq, then a dual-width module
   initial begin
      repeat (3) @(posedge I_CLK);
      I_RSTN <= 1'b1;
      xfer(1'b0, 6'h00, 32'h1234);
      for (int s = 0; s < 8; s++)
         xfer(1'b0, 6'h04 + 6'(4 * s), 32'h21);
      chk(O_IRQ, 1'b0);
      xfer(1'b1, 6'h34, 32'h10);
      scene <= 2'h1;
      @(negedge I_CLK);
      chk(O_IRQ, 1'b1);
      repeat (4) @(posedge I_CLK);
      xfer(1'b0, 6'h30, 32'hff);
      xfer(1'b0, 6'h30, 32'h70);
      for (int s = 0; s < 8; s++)
         xfer(1'b0, 6'h04 + 6'(4 * s), {8'h00, exp1[s]});
      xfer(1'b1, 6'h34, 32'h01);
      @(negedge I_CLK);
      chk(O_IRQ, 1'b0);
      xfer(1'b0, 6'h3c, 32'hbad00000);
      scene <= 2'h2;
      repeat (4) @(posedge I_CLK);
      xfer(1'b0, 6'h04, 32'h0055aa80);
      xfer(1'b0, 6'h08, 32'h0);
      end_of_test();
   end
endmodule // slot_module_diagnostic_status_bench
`default_nettype wire

/* File: verification/smd_io_model.sv */
`timescale 1ns/1ps
`default_nettype none
// slot modules: scene 0 empty rack, 1 mixed families, 2 dual digital in slots 1 and 2
module smd_io_model (
   input wire logic [1:0] i_scene,
   output logic [7:0] o_on,
   output logic [7:0] o_dual,
   output logic [23:0] o_fam,
   output logic [31:0] o_cnt,
   output logic [63:0] o_dat,
   output logic [63:0] o_inv,
   output logic [63:0] o_sim
);
   wire logic d = i_scene[1];
   // an empty rack reports no family, so no stale channel bits can leak out
   assign o_on = {8{i_scene != 2'h0}};
   assign o_dual = {6'h00, d, 1'h0};
   assign o_fam = o_on[0] ? {3'h0, 3'h1, 3'h1, 3'h1, 3'h4, 3'h3, 3'h2, 3'h1} : 24'h0;
   assign o_cnt = {24'h144421, d ? 8'h28 : 8'h24};
   assign o_dat = {48'h101, 8'hfe, d ? 8'hf0 : 8'h03};
   assign o_inv = {56'h20000, d ? 8'h0f : 8'h04};
   assign o_sim = {7'h00, o_on[0], 56'h0};
endmodule // smd_io_model
`default_nettype wire

/* File: verification/smd_status_sva.sv */
`timescale 1ns/1ps
`default_nettype none
// bus timing and status word shape, seen from the top ports only
module smd_status_sva (
   input wire logic I_CLK,
   input wire logic I_RSTN,
   input wire logic [5:0] I_AVS_ADDRESS,
   input wire logic I_AVS_READ,
   input wire logic I_AVS_WRITE,
   input wire logic [31:0] O_AVS_READDATA,
   input wire logic O_AVS_WAITREQUEST,
   input wire logic [15:0] I_GLOBAL_STATUS
);
   default clocking @(posedge I_CLK); endclocking
   default disable iff (!I_RSTN);
   // a read completes while waitrequest is low; slot words sit at 0x04 to 0x20
   wire logic w = O_AVS_WAITREQUEST;
   wire logic [31:0] q = O_AVS_READDATA;
   wire logic done = I_AVS_READ && !w;
   wire logic slot = done && I_AVS_ADDRESS >= 6'h04 && I_AVS_ADDRESS <= 6'h20;
   chk_read_wait: assert property ($rose(I_AVS_READ) |-> w ##1 !w)
      else $error("read wait state wrong");
   chk_write_wait: assert property ($rose(I_AVS_WRITE) |-> w ##1 !w)
      else $error("write wait state wrong");
   chk_global_copy: assert property (done && I_AVS_ADDRESS == 6'h00
      && $past(I_GLOBAL_STATUS, 3) == I_GLOBAL_STATUS |-> q[15:0] == I_GLOBAL_STATUS)
      else $error("coupling bytes wrong");
   chk_reserved_zero: assert property (slot |-> q[31:24] == 8'h00 && !q[4])
      else $error("reserved bit set");
   chk_code_legal: assert property (slot |-> q[3:0] != 4'h7 && q[3:0] != 4'h8 && q[3:0] < 4'hb)
      else $error("reserved error code");
   chk_error_flag: assert property (slot |-> q[5] == (q[3:0] != 4'h0))
      else $error("error flag disagrees with code");
   chk_active_code: assert property (slot && q[7] |-> q[3:0] != 4'h1)
      else $error("active slot reports timeout");
   chk_unmapped_rd: assert property (done && I_AVS_ADDRESS == 6'h3c |-> q == 32'hbad00000)
      else $error("unmapped read value wrong");
endmodule // smd_status_sva
bind smd_status smd_status_sva u_sva (.I_CLK, .I_RSTN, .I_AVS_ADDRESS, .I_AVS_READ,
   .I_AVS_WRITE, .O_AVS_READDATA, .O_AVS_WAITREQUEST, .I_GLOBAL_STATUS);
`default_nettype wire
